// >>> rtl/sfm_pkg.sv
// Constants shared by the serial flash master port
package sfm_pkg;

  // Register byte offsets
  localparam logic [15:0] EVENT_STATUS_OFS    = 16'h5020;
  localparam logic [15:0] CORE_SOFT_RESET_OFS = 16'h5040;
  localparam logic [15:0] SERIAL_CONTROL_OFS  = 16'h5060;
  localparam logic [15:0] SERIAL_STATUS_OFS   = 16'h5064;
  localparam logic [15:0] TRANSMIT_BYTE_OFS   = 16'h5068;
  localparam logic [15:0] RECEIVE_BYTE_OFS    = 16'h506C;
  localparam logic [15:0] FLASH_SELECT_OFS    = 16'h5070;

  // Soft reset key and length in clock cycles
  localparam logic [31:0] SOFT_RESET_KEY    = 32'h0000_000A;
  localparam logic [2:0]  SOFT_RESET_CYCLES = 3'h4;

  // Control field positions
  localparam int CTL_LOOPBACK   = 0;
  localparam int CTL_ENABLE     = 1;
  localparam int CTL_MASTER     = 2;
  localparam int CTL_CPOL       = 3;
  localparam int CTL_CPHA       = 4;
  localparam int CTL_TX_RESET   = 5;
  localparam int CTL_RX_RESET   = 6;
  localparam int CTL_MANUAL_SEL = 7;
  localparam int CTL_INHIBIT    = 8;
  localparam int CTL_LSB_FIRST  = 9;
  localparam int CTL_WIDTH      = 10;
  localparam logic [9:0] CTL_RESET = 10'h000;

  // Status field positions
  localparam int ST_RX_EMPTY  = 0;
  localparam int ST_RX_FULL   = 1;
  localparam int ST_TX_EMPTY  = 2;
  localparam int ST_TX_FULL   = 3;
  localparam int ST_MODE_FLT  = 4;
  localparam int ST_SLAVE_SEL = 5;
  localparam int ST_CLK_FMT   = 6;
  localparam int ST_SLAVE_ERR = 7;
  localparam int ST_ORDER_ERR = 8;

  // Event status field positions
  localparam int EV_MODE_FLT   = 0;
  localparam int EV_SLAVE_FLT  = 1;
  localparam int EV_TX_EMPTY   = 2;
  localparam int EV_RX_FULL    = 4;
  localparam int EV_RX_OVERRUN = 5;
  localparam int EV_SLAVE_SEL  = 7;
  localparam int EV_WIDTH      = 8;

  // Selection register reset: flash deselected
  localparam logic FLASH_SELECT_RESET = 1'b1;

  // Serial clock timing
  localparam int MCLK_HZ   = 125000000;
  localparam int SCK_HZ    = 31250000;
  localparam int CLK_RATIO = MCLK_HZ / (2 * SCK_HZ);
  localparam int BITS      = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL} sfm_state_t;

endpackage

// >>> rtl/sfm_spi_flash_master.sv
// Memory-mapped single-lane serial master for a configuration flash
`timescale 1ns/1ps

module sfm_spi_flash_master
  import sfm_pkg::*;
#(
  parameter int RATIO = sfm_pkg::CLK_RATIO,
  parameter int LANES = 1
)(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [31:0] regWrData,
  output logic      [31:0] regRdData,
  output logic             regAck,
  output logic             regErr,
  output logic             sclkOut,
  output logic             sclkOe,
  output logic             mosiOut,
  output logic             mosiOe,
  input  wire logic        misoIn,
  output logic             selectOutN,
  output logic             selectOe,
  input  wire logic        selInN,
  output logic             modeFaultStrobe
);
  import sfm_pkg::*;

  localparam int DIV_W = (RATIO > 1) ? $clog2(RATIO) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RATIO - 1);

  logic [2:0]          srCnt;
  logic                coreRst;
  logic [9:0]          control;
  logic                flashSel;
  logic [7:0]          txData;
  logic                txFull;
  logic [7:0]          rxData;
  logic                rxFull;
  logic [7:0]          txShift;
  logic [7:0]          rxShift;
  logic                mosiReg;
  logic                sclkReg;
  sfm_state_t          state;
  logic [DIV_W-1:0]    divCnt;
  logic                tick;
  logic [3:0]          halfCnt;
  logic                loadPulse;
  logic                xferDone;
  logic                masterRun;
  logic                inBit;
  logic                leading;
  logic                sampleEdge;
  logic                shiftEdge;
  logic [EV_WIDTH-1:0] eventStatus;
  logic [EV_WIDTH-1:0] evSet;
  logic                modeFault;
  logic                selPrev;
  logic                selFall;
  logic                mfEvent;
  logic [8:0]          status;
  logic                wrHit;
  logic                rdHit;
  logic                rdStatus;
  logic                rdRx;
  logic                wrTx;
  logic                rxDrop;

  // Bit position of serial index k in the chosen order
  function automatic logic [2:0] bitPos(input logic [2:0] k,
                                        input logic lsb);
    bitPos = lsb ? k : 3'(7 - k);
  endfunction

  // Soft reset counter; only the power reset clears it
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      srCnt <= 3'h0;
    else if (regWrEn && regAddr == CORE_SOFT_RESET_OFS
             && regWrData == SOFT_RESET_KEY)
      srCnt <= SOFT_RESET_CYCLES;
    else if (srCnt != 3'h0)
      srCnt <= srCnt - 3'h1;
  end

  assign coreRst = !rstn || (srCnt != 3'h0);

  // Access decode
  assign wrHit    = regWrEn && !coreRst;
  assign rdHit    = regRdEn && !coreRst;
  assign rdStatus = rdHit && regAddr == SERIAL_STATUS_OFS;
  assign rdRx     = rdHit && regAddr == RECEIVE_BYTE_OFS;
  assign wrTx     = wrHit && regAddr == TRANSMIT_BYTE_OFS && !txFull;

  // Control register; FIFO reset bits are not stored
  always_ff @(posedge mclk)
  begin
    if (coreRst)
      control <= CTL_RESET;
    else if (wrHit && regAddr == SERIAL_CONTROL_OFS)
    begin
      control <= regWrData[CTL_WIDTH-1:0];
      control[CTL_TX_RESET] <= 1'b0;
      control[CTL_RX_RESET] <= 1'b0;
    end
  end

  // Flash select register, active low
  always_ff @(posedge mclk)
  begin
    if (coreRst)
      flashSel <= FLASH_SELECT_RESET;
    else if (wrHit && regAddr == FLASH_SELECT_OFS)
      flashSel <= regWrData[0];
  end

  // Master may run only when enabled, master and not inhibited
  assign masterRun = control[CTL_ENABLE] && control[CTL_MASTER]
                     && !control[CTL_INHIBIT];
  assign loadPulse = (state == ST_IDLE) && masterRun && txFull;

  // Single transmit holding register
  always_ff @(posedge mclk)
  begin
    if (coreRst)
    begin
      txData <= 8'h00;
      txFull <= 1'b0;
    end
    else if (wrHit && regAddr == SERIAL_CONTROL_OFS
             && regWrData[CTL_TX_RESET])
      txFull <= 1'b0;
    else if (wrTx)
    begin
      txData <= regWrData[7:0];
      txFull <= 1'b1;
    end
    else if (loadPulse)
      txFull <= 1'b0;
  end

  // Drop newest byte while the old one is unread
  assign rxDrop = xferDone && rxFull && !rdRx;

  // Single receive register; a read in the same cycle makes room
  always_ff @(posedge mclk)
  begin
    if (coreRst)
    begin
      rxData <= 8'h00;
      rxFull <= 1'b0;
    end
    else if (wrHit && regAddr == SERIAL_CONTROL_OFS
             && regWrData[CTL_RX_RESET])
      rxFull <= 1'b0;
    else if (xferDone && !rxDrop)
    begin
      rxData <= rxShift;
      rxFull <= 1'b1;
    end
    else if (rdRx)
      rxFull <= 1'b0;
  end

  // Half period divider, runs only during a transfer
  always_ff @(posedge mclk)
  begin
    if (coreRst || state == ST_IDLE)
      divCnt <= '0;
    else if (divCnt == DIV_LAST)
      divCnt <= '0;
    else
      divCnt <= divCnt + DIV_W'(1);
  end

  assign tick = (state != ST_IDLE) && (divCnt == DIV_LAST);

  // Edge classification for the current half period
  assign leading    = !halfCnt[0];
  assign sampleEdge = control[CTL_CPHA] ? !leading : leading;
  assign shiftEdge  = control[CTL_CPHA] ? (leading && halfCnt != 4'h0)
                    : (!leading && halfCnt != 4'hF);
  assign inBit      = control[CTL_LOOPBACK] ? mosiReg : misoIn;
  assign xferDone   = (state == ST_TAIL) && tick;

  // Transfer engine; abort keeps hazards short if software misbehaves
  always_ff @(posedge mclk)
  begin
    if (coreRst)
    begin
      state   <= ST_IDLE;
      halfCnt <= 4'h0;
      sclkReg <= 1'b0;
      mosiReg <= 1'b0;
      txShift <= 8'h00;
      rxShift <= 8'h00;
    end
    else if (state != ST_IDLE && !masterRun)
    begin
      state   <= ST_IDLE;
      sclkReg <= control[CTL_CPOL];
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          sclkReg <= control[CTL_CPOL];
          halfCnt <= 4'h0;
          if (loadPulse)
          begin
            txShift <= txData;
            mosiReg <= txData[bitPos(3'h0, control[CTL_LSB_FIRST])];
            state   <= ST_LEAD;
          end
        end
        ST_LEAD:
          if (tick)
            state <= ST_SHIFT;
        ST_SHIFT:
          if (tick)
          begin
            sclkReg <= !sclkReg;
            if (sampleEdge)
              rxShift[bitPos(halfCnt[3:1], control[CTL_LSB_FIRST])]
                <= inBit;
            if (shiftEdge && control[CTL_CPHA])
              mosiReg <= txShift[bitPos(halfCnt[3:1],
                                        control[CTL_LSB_FIRST])];
            else if (shiftEdge)
              mosiReg <= txShift[bitPos(3'(halfCnt[3:1] + 3'h1),
                                        control[CTL_LSB_FIRST])];
            halfCnt <= halfCnt + 4'h1;
            if (halfCnt == 4'hF)
              state <= ST_TAIL;
          end
        ST_TAIL:
          if (tick)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Select input edge tracking
  always_ff @(posedge mclk)
  begin
    if (coreRst)
      selPrev <= 1'b1;
    else
      selPrev <= selInN;
  end

  assign selFall = selPrev && !selInN;
  assign mfEvent = selFall && control[CTL_MASTER];

  // Mode fault flag; new fault wins over the clearing read
  always_ff @(posedge mclk)
  begin
    if (coreRst)
      modeFault <= 1'b0;
    else
      modeFault <= (modeFault && !rdStatus) || mfEvent;
  end

  // One cycle strobe on the rising edge of the fault flag
  always_ff @(posedge mclk)
  begin
    if (coreRst)
      modeFaultStrobe <= 1'b0;
    else
      modeFaultStrobe <= mfEvent && !modeFault;
  end

  // Event sources; a mode fault is also reported in the status word, and on the modeFaultStrobe pin only while the fault flag is clear
  always_comb
  begin
    evSet                = '0;
    evSet[EV_MODE_FLT]   = mfEvent;
    evSet[EV_SLAVE_FLT]  = !selInN && !control[CTL_MASTER]
                           && !control[CTL_ENABLE];
    evSet[EV_TX_EMPTY]   = loadPulse;
    evSet[EV_RX_FULL]    = xferDone && !rxDrop;
    evSet[EV_RX_OVERRUN] = rxDrop;
    evSet[EV_SLAVE_SEL]  = selFall && !control[CTL_MASTER];
  end

  // Toggle on write; a new event wins over the toggle
  always_ff @(posedge mclk)
  begin
    if (coreRst)
      eventStatus <= '0;
    else if (wrHit && regAddr == EVENT_STATUS_OFS)
      eventStatus <= (eventStatus ^ regWrData[EV_WIDTH-1:0]) | evSet;
    else
      eventStatus <= eventStatus | evSet;
  end

  // Status word, all live except the mode fault flag
  always_comb
  begin
    status               = '0;
    status[ST_RX_EMPTY]  = !rxFull;
    status[ST_RX_FULL]   = rxFull;
    status[ST_TX_EMPTY]  = !txFull;
    status[ST_TX_FULL]   = txFull;
    status[ST_MODE_FLT]  = modeFault;
    status[ST_SLAVE_SEL] = !(!control[CTL_MASTER] && !selInN);
    status[ST_CLK_FMT]   = control[CTL_CPOL] ^ control[CTL_CPHA];
    status[ST_SLAVE_ERR] = (LANES > 1) && !control[CTL_MASTER];
    status[ST_ORDER_ERR] = (LANES > 1) && control[CTL_LSB_FIRST];
  end

  // Bus answer one cycle after the request; status writes are dropped
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      regAck    <= 1'b0;
      regErr    <= 1'b0;
      regRdData <= 32'h0000_0000;
    end
    else
    begin
      regAck    <= regWrEn || regRdEn;
      regErr    <= 1'b0;
      regRdData <= 32'h0000_0000;
      if (regWrEn)
      begin
        case (regAddr)
          CORE_SOFT_RESET_OFS:
            regErr <= regWrData != SOFT_RESET_KEY;
          TRANSMIT_BYTE_OFS:
            regErr <= txFull;
          EVENT_STATUS_OFS, SERIAL_CONTROL_OFS, SERIAL_STATUS_OFS,
          RECEIVE_BYTE_OFS, FLASH_SELECT_OFS:
            regErr <= 1'b0;
          default:
            regErr <= 1'b1;
        endcase
      end
      else if (regRdEn)
      begin
        case (regAddr)
          EVENT_STATUS_OFS:
            regRdData <= {24'h000000, eventStatus};
          SERIAL_CONTROL_OFS:
            regRdData <= {22'h000000, control};
          SERIAL_STATUS_OFS:
            regRdData <= {23'h000000, status};
          RECEIVE_BYTE_OFS:
            regRdData <= {24'h000000, rxData};
          FLASH_SELECT_OFS:
            regRdData <= {31'h00000000, flashSel};
          CORE_SOFT_RESET_OFS, TRANSMIT_BYTE_OFS:
            regRdData <= 32'h0000_0000;
          default:
            regErr <= 1'b1;
        endcase
      end
    end
  end

  // Pin drive; outputs float unless an enabled master
  assign sclkOe  = control[CTL_ENABLE] && control[CTL_MASTER];
  assign mosiOe  = sclkOe;
  assign selectOe = sclkOe;
  assign sclkOut = sclkReg;
  assign mosiOut = mosiReg;
  // Manual select follows register; automatic asserts during a transfer
  assign selectOutN = control[CTL_MANUAL_SEL] ? flashSel
                      : (state == ST_IDLE);

endmodule

// >>> verification/sfm_master_properties.sv
// Concurrent checks on the serial flash master port
`timescale 1ns/1ps
module sfm_master_checker
  import sfm_pkg::*;
#(
  parameter int RATIO = 2,
  parameter int LANES = 1
)(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [15:0] regAddr,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [31:0] regWrData,
  input wire logic        regAck,
  input wire logic        regErr,
  input wire logic        sclkOut,
  input wire logic        sclkOe,
  input wire logic        mosiOe,
  input wire logic        selectOutN,
  input wire logic        selectOe,
  input wire logic        selInN,
  input wire logic        modeFaultStrobe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Decoded writes to the reset register
  logic keyWr;
  logic badWr;
  assign keyWr = regWrEn && regAddr == CORE_SOFT_RESET_OFS
                 && regWrData == SOFT_RESET_KEY;
  assign badWr = regWrEn && regAddr == CORE_SOFT_RESET_OFS
                 && regWrData != SOFT_RESET_KEY;

  a_ack_next_cycle:
    assert property ((regWrEn || regRdEn) |=> regAck)
    else $error("access not acknowledged");
  a_bad_key_error:
    assert property (badWr |=> regAck && regErr)
    else $error("bad reset key accepted");
  // Core held in reset: outputs released, select idle
  a_soft_reset_idle:
    assert property (keyWr |=> !regErr ##2 (!sclkOe && selectOutN)[*2])
    else $error("core active during soft reset");
  a_status_write_ok:
    assert property (regWrEn && regAddr == SERIAL_STATUS_OFS |=> !regErr)
    else $error("status write refused");
  a_strobe_one_cycle:
    assert property (modeFaultStrobe |=> !modeFaultStrobe)
    else $error("fault strobe too long");
  a_strobe_has_cause:
    assert property (modeFaultStrobe |-> !$past(selInN) ||
                     !$past(selInN, 2) || !$past(selInN, 3))
    else $error("fault strobe without select");
  a_enables_together:
    assert property (sclkOe == mosiOe && mosiOe == selectOe)
    else $error("output enables disagree");
  // Ratio two: each clock level lasts two cycles within a frame
  a_sclk_half_period:
    assert property ($changed(sclkOut) && !selectOutN |=> $stable(sclkOut))
    else $error("serial clock level too short");

  c_frame: cover property ($fell(selectOutN));
  c_fault: cover property (modeFaultStrobe);
  c_error: cover property (regAck && regErr);
endmodule

// >>> verification/sfm_flash_model.sv
// Behavioural serial flash: answers a fixed byte, MSB first
`timescale 1ns/1ps
module sfm_flash_model #(
  parameter logic [7:0] REPLY = 8'h35
)(
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic       mosi,
  output logic           miso,
  output logic     [7:0] seen
);
  logic [7:0] outSh = 8'h00;

  // Load reply on select, shift out on falling clock
  always @(negedge csN) outSh <= REPLY;
  always @(negedge sclk) if (!csN) outSh <= {outSh[6:0], 1'b0};
  // Capture command bits on rising clock
  always @(posedge sclk) if (!csN) seen <= {seen[6:0], mosi};
  // Released line shows inverse, so a stale value never passes
  assign miso = csN ? ~outSh[7] : outSh[7];
endmodule

// >>> verification/test_sfm_spi_flash_master.sv
// Self-checking bench for the serial flash master port
`timescale 1ns/1ps
module test_sfm_spi_flash_master;
  import sfm_pkg::*;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        selInN = 1'b1;
  logic [31:0] regRdData;
  logic        regAck, regErr, sclkOut, sclkOe, mosiOut, mosiOe;
  logic        misoIn, selectOutN, selectOe, modeFaultStrobe;
  logic        fClk, fSelN, fData, e;
  logic [7:0]  fSeen;
  logic [31:0] q;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          strobes = 0;

  always #4 mclk = ~mclk;
  // Released lines: clock pulled low, select pulled high
  assign fClk  = sclkOe ? sclkOut : 1'b0;
  assign fSelN = selectOe ? selectOutN : 1'b1;
  assign fData = mosiOe ? mosiOut : 1'b1;

  sfm_spi_flash_master dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regAck(regAck), .regErr(regErr),
    .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoIn), .selectOutN(selectOutN), .selectOe(selectOe),
    .selInN(selInN), .modeFaultStrobe(modeFaultStrobe));
  sfm_flash_model flash (.sclk(fClk), .csN(fSelN), .mosi(fData),
    .miso(misoIn), .seen(fSeen));

  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus access; answer comes one cycle after the request
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [31:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrEn   <= w;
    regRdEn   <= !w;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    #1;
    q = regRdData;
    e = regErr;
    check("ack", {31'h0, regAck}, 32'h1);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic er);
    access(1'b1, a, d);
    check($sformatf("err %h", a), {31'h0, e}, {31'h0, er});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] m, exp);
    access(1'b0, a, 32'h0);
    check($sformatf("read %h", a), q & m, exp);
  endtask
  // Bounded poll for a status bit
  task automatic waitBit(input logic [15:0] a, input int b);
    q = 32'h0;
    for (int i = 0; i < 100 && q[b] !== 1'b1; i++)
      access(1'b0, a, 32'h0);
  endtask
  // Byte out, wait for the answer, read it before the next load
  task automatic xfer(input logic [31:0] d, exp);
    wr(TRANSMIT_BYTE_OFS, d, 1'b0);
    waitBit(SERIAL_STATUS_OFS, ST_RX_FULL);
    rd(RECEIVE_BYTE_OFS, 32'hFF, exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard and fault strobe count
  always @(posedge mclk)
  begin
    cycles++;
    strobes += modeFaultStrobe;
    if (cycles == 30000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(SERIAL_CONTROL_OFS, 32'hFFFFFFFF, 32'h0);
    rd(SERIAL_STATUS_OFS, 32'h1FF, 32'h025);
    rd(FLASH_SELECT_OFS, 32'h1, 32'h1);
    wr(16'h5000, 32'h0, 1'b1);
    wr(SERIAL_STATUS_OFS, 32'h1FF, 1'b0);
    rd(SERIAL_STATUS_OFS, 32'h1FF, 32'h025);
    $display("test reset values done");
    for (int m = 0; m < 4; m++)
    begin
      wr(SERIAL_CONTROL_OFS, 32'h66 | 32'(m << 3), 1'b0);
      rd(SERIAL_CONTROL_OFS, 32'h3FF, 32'h06 | 32'(m << 3));
      rd(SERIAL_STATUS_OFS, 32'h40, (m == 1 || m == 2) ? 32'h40 : 0);
      check("idle clock", {31'h0, sclkOut}, 32'(m & 1));
      check("enabled", {31'h0, sclkOe}, 32'h1);
    end
    wr(SERIAL_CONTROL_OFS, 32'h200, 1'b0);
    check("disabled", {31'h0, sclkOe}, 32'h0);
    rd(SERIAL_STATUS_OFS, 32'h180, 32'h0);
    $display("test control modes done");
    wr(SERIAL_CONTROL_OFS, 32'h006, 1'b0);
    xfer(32'h1E, 32'h35);
    check("flash byte", {24'h0, fSeen}, 32'h1E);
    rd(SERIAL_STATUS_OFS, 32'h7, 32'h5);
    check("deselect", {31'h0, selectOutN}, 32'h1);
    wr(SERIAL_CONTROL_OFS, 32'h206, 1'b0);
    xfer(32'h1E, 32'hAC);
    check("flash lsb", {24'h0, fSeen}, 32'h78);
    wr(SERIAL_CONTROL_OFS, 32'h01F, 1'b0);
    xfer(32'hC3, 32'hC3);
    $display("test transfers done");
    wr(SERIAL_CONTROL_OFS, 32'h007, 1'b0);
    wr(TRANSMIT_BYTE_OFS, 32'h11, 1'b0);
    waitBit(SERIAL_STATUS_OFS, ST_RX_FULL);
    wr(TRANSMIT_BYTE_OFS, 32'h22, 1'b0);
    waitBit(EVENT_STATUS_OFS, EV_RX_OVERRUN);
    rd(EVENT_STATUS_OFS, 32'h20, 32'h20);
    rd(RECEIVE_BYTE_OFS, 32'hFF, 32'h11);
    // Toggle on write must clear the overrun event again
    wr(EVENT_STATUS_OFS, 32'h20, 1'b0);
    rd(EVENT_STATUS_OFS, 32'h20, 32'h0);
    wr(SERIAL_CONTROL_OFS, 32'h004, 1'b0);
    wr(TRANSMIT_BYTE_OFS, 32'h55, 1'b0);
    wr(TRANSMIT_BYTE_OFS, 32'h66, 1'b1);
    rd(SERIAL_STATUS_OFS, 32'hC, 32'h8);
    wr(SERIAL_CONTROL_OFS, 32'h024, 1'b0);
    rd(SERIAL_STATUS_OFS, 32'hC, 32'h4);
    $display("test overrun and full done");
    wr(SERIAL_CONTROL_OFS, 32'h106, 1'b0);
    wr(TRANSMIT_BYTE_OFS, 32'h77, 1'b0);
    repeat (60) @(posedge mclk);
    rd(SERIAL_STATUS_OFS, 32'hA, 32'h8);
    wr(CORE_SOFT_RESET_OFS, SOFT_RESET_KEY, 1'b0);
    repeat (8) @(posedge mclk);
    rd(SERIAL_CONTROL_OFS, 32'h3FF, 32'h0);
    rd(SERIAL_STATUS_OFS, 32'hF, 32'h5);
    wr(CORE_SOFT_RESET_OFS, 32'h5, 1'b1);
    $display("test inhibit and soft reset done");
    wr(SERIAL_CONTROL_OFS, 32'h086, 1'b0);
    wr(FLASH_SELECT_OFS, 32'h0, 1'b0);
    check("manual low", {31'h0, selectOutN}, 32'h0);
    wr(FLASH_SELECT_OFS, 32'h1, 1'b0);
    check("manual high", {31'h0, selectOutN}, 32'h1);
    wr(SERIAL_CONTROL_OFS, 32'h004, 1'b0);
    // Inputs move only on the rising edge
    @(posedge mclk);
    selInN <= 1'b0;
    repeat (6) @(posedge mclk);
    check("strobes", 32'(strobes), 32'h1);
    rd(SERIAL_STATUS_OFS, 32'h10, 32'h10);
    rd(SERIAL_STATUS_OFS, 32'h10, 32'h0);
    wr(SERIAL_CONTROL_OFS, 32'h000, 1'b0);
    rd(SERIAL_STATUS_OFS, 32'h20, 32'h0);
    @(posedge mclk);
    selInN <= 1'b1;
    $display("test select and fault done");
    results();
  end
endmodule

bind sfm_spi_flash_master sfm_master_checker #(.RATIO(RATIO), .LANES(LANES))
  chk (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regAck(regAck),
    .regErr(regErr), .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiOe(mosiOe),
    .selectOutN(selectOutN), .selectOe(selectOe), .selInN(selInN),
    .modeFaultStrobe(modeFaultStrobe));
